// ---- rtl/converter_config_registers.sv ----
// axi4-lite register bank with mux routing and calibration/divider reset control
`timescale 1ns/10ps
module converter_config_registers (
	input wire logic aclk, // 50 MHz clock
	input wire logic aresetn, // synchronous reset, active low
	input wire logic [conv_cfg_pkg::addr_w-1:0] s_axi_awaddr, // write byte address
	input wire logic s_axi_awvalid, // write address valid
	output logic s_axi_awready, // write address ready
	input wire logic [31:0] s_axi_wdata, // write data
	input wire logic [3:0] s_axi_wstrb, // write strobes
	input wire logic s_axi_wvalid, // write data valid
	output logic s_axi_wready, // write data ready
	output logic [1:0] s_axi_bresp, // write response
	output logic s_axi_bvalid, // write response valid
	input wire logic s_axi_bready, // write response ready
	input wire logic [conv_cfg_pkg::addr_w-1:0] s_axi_araddr, // read byte address
	input wire logic s_axi_arvalid, // read address valid
	output logic s_axi_arready, // read address ready
	output logic [31:0] s_axi_rdata, // read data
	output logic [1:0] s_axi_rresp, // read response
	output logic s_axi_rvalid, // read data valid
	input wire logic s_axi_rready, // read data ready
	input wire logic channel_mode_single, // channel mode selector picks single-channel
	output conv_cfg_pkg::preemph_s lane_preemph [conv_cfg_pkg::lanes], // per-lane drive
	output logic [2:0] charge_pump_scale, // pll charge-pump current code
	output conv_cfg_pkg::route_s input_route, // active mux routing
	output logic cal_run, // calibration runs when high
	output logic divider_reset // digital and link divider reset
);
	logic [7:0] reg_preemph;
	logic [7:0] reg_cp;
	logic [7:0] reg_insel;
	logic [7:0] reg_calen;
	logic [conv_cfg_pkg::addr_w-1:0] aw_addr;
	logic [conv_cfg_pkg::addr_w-3:0] aw_index;
	logic [conv_cfg_pkg::addr_w-3:0] ar_index;
	logic wr_pe;
	logic wr_cp;
	logic wr_is;
	logic wr_ce;
	logic aw_held;
	logic [31:0] w_data;
	logic [3:0] w_strb;
	logic w_held;
	logic do_write;
	logic cal_en_q;
	logic cal_start;
	logic mode_s1;
	logic mode_s2;
	conv_cfg_pkg::route_s next_route;

	// both channels may arrive in either order; hold each until the pair is complete
	assign s_axi_awready = !aw_held && !s_axi_bvalid;
	assign s_axi_wready = !w_held && !s_axi_bvalid;
	assign do_write = aw_held && w_held && !s_axi_bvalid;
	assign s_axi_arready = !s_axi_rvalid;

	// word index of the byte address; byte lane 0 carries each register
	assign aw_index = aw_addr[conv_cfg_pkg::addr_w-1:2];
	assign ar_index = s_axi_araddr[conv_cfg_pkg::addr_w-1:2];
	assign wr_pe = do_write && w_strb[0] && aw_index == conv_cfg_pkg::addr_preemph;
	assign wr_cp = do_write && w_strb[0] && aw_index == conv_cfg_pkg::addr_cp;
	assign wr_is = do_write && w_strb[0] && aw_index == conv_cfg_pkg::addr_insel;
	assign wr_ce = do_write && w_strb[0] && aw_index == conv_cfg_pkg::addr_calen;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held <= 1'b0;
			aw_addr <= '0;
		end else if (s_axi_awvalid && s_axi_awready) begin
			aw_held <= 1'b1;
			aw_addr <= s_axi_awaddr;
		end else if (do_write) begin
			aw_held <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			w_held <= 1'b0;
			w_data <= 32'h00000000;
			w_strb <= 4'h0;
		end else if (s_axi_wvalid && s_axi_wready) begin
			w_held <= 1'b1;
			w_data <= s_axi_wdata;
			w_strb <= s_axi_wstrb;
		end else if (do_write) begin
			w_held <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= conv_cfg_pkg::resp_okay;
		end else if (do_write) begin
			s_axi_bvalid <= 1'b1;
			case (aw_index)
				conv_cfg_pkg::addr_preemph, conv_cfg_pkg::addr_cp,
				conv_cfg_pkg::addr_insel, conv_cfg_pkg::addr_calen: begin
					s_axi_bresp <= conv_cfg_pkg::resp_okay;
				end
				default: begin
					s_axi_bresp <= conv_cfg_pkg::resp_slverr;
				end
			endcase
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// reserved bits are stored and read back as written
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			reg_preemph <= conv_cfg_pkg::rst_preemph;
		end else if (wr_pe) begin
			reg_preemph <= w_data[7:0];
		end
	end

	// charge-pump scale register
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			reg_cp <= conv_cfg_pkg::rst_cp;
		end else if (wr_cp) begin
			reg_cp <= w_data[7:0];
		end
	end

	// input select and calibration enable sit in words of their own
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			reg_insel <= conv_cfg_pkg::rst_insel;
		end else if (wr_is) begin
			reg_insel <= w_data[7:0];
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			reg_calen <= conv_cfg_pkg::rst_calen;
		end else if (wr_ce) begin
			reg_calen <= w_data[7:0];
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= conv_cfg_pkg::resp_okay;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp <= conv_cfg_pkg::resp_okay;
			case (ar_index)
				conv_cfg_pkg::addr_preemph: begin
					s_axi_rdata <= {24'h000000, reg_preemph};
				end
				conv_cfg_pkg::addr_cp: begin
					s_axi_rdata <= {24'h000000, reg_cp};
				end
				conv_cfg_pkg::addr_insel: begin
					s_axi_rdata <= {24'h000000, reg_insel};
				end
				conv_cfg_pkg::addr_calen: begin
					s_axi_rdata <= {24'h000000, reg_calen};
				end
				default: begin
					s_axi_rdata <= 32'h00000000;
					s_axi_rresp <= conv_cfg_pkg::resp_slverr;
				end
			endcase
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	// lane drive copies one global setting
	generate
		for (genvar i = 0; i < conv_cfg_pkg::lanes; i++) begin : g_lane
			assign lane_preemph[i] = {reg_preemph[2:0], reg_preemph[conv_cfg_pkg::pe_boost_bit]};
		end
	endgenerate

	assign charge_pump_scale = reg_cp[2:0];

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cal_en_q <= conv_cfg_pkg::rst_calen[conv_cfg_pkg::cal_en_bit];
		end else begin
			cal_en_q <= reg_calen[conv_cfg_pkg::cal_en_bit];
		end
	end

	assign cal_run = reg_calen[conv_cfg_pkg::cal_en_bit];
	assign divider_reset = !reg_calen[conv_cfg_pkg::cal_en_bit];
	assign cal_start = cal_run && !cal_en_q;

	// mode level comes from another block's timing; resynchronise
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			mode_s1 <= 1'b0;
			mode_s2 <= 1'b0;
		end else begin
			mode_s1 <= channel_mode_single;
			mode_s2 <= mode_s1;
		end
	end

	always_comb begin
		next_route = '0;
		if (mode_s2) begin
			// swap ignored here
			case (reg_insel[1:0])
				conv_cfg_pkg::sel_b: begin
					next_route.ch_a_from_b = 1'b1;
				end
				conv_cfg_pkg::sel_both: begin
					next_route.ch_b_active = 1'b1;
				end
				default: begin
					next_route = '0;
				end
			endcase
		end else begin
			// single selection ignored here
			next_route.ch_b_active = 1'b1;
			next_route.ch_a_from_b = reg_insel[conv_cfg_pkg::swap_bit];
			next_route.ch_b_from_a = reg_insel[conv_cfg_pkg::swap_bit];
		end
	end

	// routing latches only when a calibration run begins
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			input_route <= '0;
		end else if (cal_start) begin
			input_route <= next_route;
		end
	end

	chk_cal_reset_div: assert property (@(posedge aclk) disable iff (!aresetn)
		divider_reset == !reg_calen[conv_cfg_pkg::cal_en_bit])
		else $error("divider reset does not follow calibration enable");
	chk_route_hold: assert property (@(posedge aclk) disable iff (!aresetn)
		!$past(cal_start) |-> $stable(input_route))
		else $error("routing changed without calibration start");
	chk_cp_follow: assert property (@(posedge aclk) disable iff (!aresetn)
		wr_cp |=> charge_pump_scale == $past(w_data[2:0]))
		else $error("charge pump scale mismatch");
	chk_lane_all: assert property (@(posedge aclk) disable iff (!aresetn)
		lane_preemph[conv_cfg_pkg::lanes-1] == lane_preemph[0])
		else $error("lanes disagree");
	chk_boost_bit: assert property (@(posedge aclk) disable iff (!aresetn)
		lane_preemph[0].extra == reg_preemph[conv_cfg_pkg::pe_boost_bit])
		else $error("boost not applied");
	chk_cal_run: assert property (@(posedge aclk) disable iff (!aresetn)
		cal_run == reg_calen[conv_cfg_pkg::cal_en_bit])
		else $error("cal run mismatch");
	chk_swap_dual: assert property (@(posedge aclk) disable iff (!aresetn)
		cal_start && !mode_s2 |=> input_route.ch_a_from_b == $past(reg_insel[conv_cfg_pkg::swap_bit]))
		else $error("dual swap wrong");
	chk_single_noswap: assert property (@(posedge aclk) disable iff (!aresetn)
		cal_start && mode_s2 |=> !input_route.ch_b_from_a)
		else $error("swap applied in single mode");
	chk_dual_nosel: assert property (@(posedge aclk) disable iff (!aresetn)
		cal_start && !mode_s2 |=> input_route.ch_b_active)
		else $error("single select applied in dual mode");
	chk_single_sel: assert property (@(posedge aclk) disable iff (!aresetn)
		cal_start && mode_s2 && reg_insel[1:0] == conv_cfg_pkg::sel_b |=> input_route.ch_a_from_b)
		else $error("input b not selected");
	chk_single_a: assert property (@(posedge aclk) disable iff (!aresetn)
		cal_start && mode_s2 && reg_insel[1:0] == conv_cfg_pkg::sel_a |=> input_route == '0)
		else $error("input a not selected");
	chk_single_both: assert property (@(posedge aclk) disable iff (!aresetn)
		cal_start && mode_s2 && reg_insel[1:0] == conv_cfg_pkg::sel_both
		|=> input_route.ch_b_active && !input_route.ch_a_from_b)
		else $error("split input selection wrong");
	chk_swap_b_side: assert property (@(posedge aclk) disable iff (!aresetn)
		cal_start && !mode_s2 |=> input_route.ch_b_from_a == $past(reg_insel[conv_cfg_pkg::swap_bit]))
		else $error("dual swap wrong on channel b");
	chk_cal_clear: assert property (@(posedge aclk) disable iff (!aresetn)
		wr_ce && !w_data[conv_cfg_pkg::cal_en_bit] |=> !cal_run && divider_reset)
		else $error("clearing calibration enable had no effect");
	chk_cal_set: assert property (@(posedge aclk) disable iff (!aresetn)
		wr_ce && w_data[conv_cfg_pkg::cal_en_bit] |=> cal_run && !divider_reset)
		else $error("setting calibration enable had no effect");
	chk_pe_write: assert property (@(posedge aclk) disable iff (!aresetn)
		wr_pe |=> lane_preemph[0] == {$past(w_data[2:0]), $past(w_data[conv_cfg_pkg::pe_boost_bit])})
		else $error("pre-emphasis write not applied");

	// bus answers stand until taken
	chk_bresp_hold: assert property (@(posedge aclk) disable iff (!aresetn)
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped before taken");
	chk_rdata_hold: assert property (@(posedge aclk) disable iff (!aresetn)
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
		else $error("read data dropped before taken");
	chk_write_answer: assert property (@(posedge aclk) disable iff (!aresetn)
		do_write |=> s_axi_bvalid)
		else $error("write response missing");
	chk_read_answer: assert property (@(posedge aclk) disable iff (!aresetn)
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read data missing");
endmodule

// ---- rtl/conv_cfg_pkg.sv ----
// constants and types for the converter configuration register bank
// Summary of operation
// - one 3-bit pre-emphasis field drives all 16 serial lanes of both groups
// - 3-bit charge-pump scale: 0..7 map -70% to +100%, reset code 3 nominal
// - dual-channel: swap 0 routes A to A, B to B; swap 1 crosses them
// - swap bit has no effect in single-channel modes
// - single-channel input: 1 input A, 2 input B, 3 both; 0 reserved
// - single-channel selection has no effect outside single-channel modes
// - input mux changes take effect only after a new calibration run
// - calibration runs while enable bit 0 is high, held in reset when low
// - clearing calibration enable also resets digital and link clock dividers
package conv_cfg_pkg;
	// register indexes; each register owns the aligned word at four times its index
	localparam int addr_w = 10;
	localparam logic [7:0] addr_preemph = 8'h48;
	localparam logic [7:0] addr_cp = 8'h4f;
	localparam logic [7:0] addr_insel = 8'h60;
	localparam logic [7:0] addr_calen = 8'h61;
	localparam logic [7:0] rst_preemph = 8'h00;
	localparam logic [7:0] rst_cp = 8'h13;
	localparam logic [7:0] rst_insel = 8'h01;
	localparam logic [7:0] rst_calen = 8'h01;
	localparam int lanes = 16;
	localparam int pe_boost_bit = 3;
	localparam int swap_bit = 4;
	localparam int cal_en_bit = 0;
	localparam logic [1:0] sel_reserved = 2'h0;
	localparam logic [1:0] sel_a = 2'h1;
	localparam logic [1:0] sel_b = 2'h2;
	localparam logic [1:0] sel_both = 2'h3;
	localparam logic [1:0] resp_okay = 2'h0;
	localparam logic [1:0] resp_slverr = 2'h2;
	// routing seen by the analog front end
	typedef struct packed {
		logic ch_a_from_b;   // channel a samples input b
		logic ch_b_from_a;   // channel b samples input a
		logic ch_b_active;   // channel b converts
	} route_s;
	// serializer drive setting shared by every lane
	typedef struct packed {
		logic [2:0] level;
		logic extra;
	} preemph_s;
endpackage

// ---- sim/converter_config_registers_tb.sv ----
// self-checking bench for the converter configuration register bank
`timescale 1ns/10ps
module converter_config_registers_tb;
	localparam logic [1:0] ok = conv_cfg_pkg::resp_okay;
	localparam logic [1:0] err = conv_cfg_pkg::resp_slverr;
	localparam logic [conv_cfg_pkg::addr_w-1:0] a_pe = {conv_cfg_pkg::addr_preemph, 2'h0};
	localparam logic [conv_cfg_pkg::addr_w-1:0] a_cp = {conv_cfg_pkg::addr_cp, 2'h0};
	localparam logic [conv_cfg_pkg::addr_w-1:0] a_is = {conv_cfg_pkg::addr_insel, 2'h0};
	localparam logic [conv_cfg_pkg::addr_w-1:0] a_ce = {conv_cfg_pkg::addr_calen, 2'h0};
	logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, mode;
	logic awready, wready, bvalid, arready, rvalid, cal_run, divider_reset;
	logic [conv_cfg_pkg::addr_w-1:0] awaddr, araddr;
	logic [7:0] d;
	logic [31:0] wdata, rdata, w;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp;
	logic [2:0] cp, prev;
	conv_cfg_pkg::preemph_s lane_preemph [conv_cfg_pkg::lanes];
	conv_cfg_pkg::route_s route;
	int miscompares, cmp_count;
	converter_config_registers converter_config_registers_inst (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.channel_mode_single(mode), .lane_preemph(lane_preemph), .charge_pump_scale(cp),
		.input_route(route), .cal_run(cal_run), .divider_reset(divider_reset));
	initial begin
		aclk = 1'b0;
		forever #10 aclk = ~aclk;
	end
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			miscompares++;
			$display("BAD at %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic test_done();
		$display("mismatches %0d comparisons %0d", miscompares, cmp_count);
		if (miscompares == 0 && cmp_count > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	task automatic give_up(input logic done);
		if (!done) begin
			miscompares++;
			test_done();
		end
	endtask
	// handshakes are judged at the falling edge, acted on at the next rising edge
	task automatic wr(input logic [conv_cfg_pkg::addr_w-1:0] a, input logic [31:0] v, input logic [3:0] s,
		input logic [1:0] er);
		logic at, wt, bt;
		logic [1:0] r;
		bt = 1'b0;
		@(posedge aclk);
		awaddr <= a;
		wdata <= v;
		wstrb <= s;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (int n = 0; n < 50 && !bt; n++) begin
			@(negedge aclk);
			at = awvalid && awready;
			wt = wvalid && wready;
			bt = bvalid;
			r = bresp;
			@(posedge aclk);
			if (at) awvalid <= 1'b0;
			if (wt) wvalid <= 1'b0;
		end
		give_up(bt);
		bready <= 1'b0;
		@(negedge aclk);
		chk({30'h0, r}, {30'h0, er});
	endtask
	task automatic rdw(input logic [conv_cfg_pkg::addr_w-1:0] a, input logic [31:0] ed,
		input logic [1:0] er);
		logic at, rt;
		logic [31:0] v;
		logic [1:0] r;
		rt = 1'b0;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (int n = 0; n < 50 && !rt; n++) begin
			@(negedge aclk);
			at = arvalid && arready;
			rt = rvalid;
			v = rdata;
			r = rresp;
			@(posedge aclk);
			if (at) arvalid <= 1'b0;
		end
		give_up(rt);
		rready <= 1'b0;
		@(negedge aclk);
		chk(v, ed);
		chk({30'h0, r}, {30'h0, er});
	endtask
	task automatic reset_vals();
		rdw(a_pe, {24'h0, conv_cfg_pkg::rst_preemph}, ok);
		rdw(a_cp, {24'h0, conv_cfg_pkg::rst_cp}, ok);
		rdw(a_is, {24'h0, conv_cfg_pkg::rst_insel}, ok);
		rdw(a_ce, {24'h0, conv_cfg_pkg::rst_calen}, ok);
		chk({29'h0, cp}, {29'h0, conv_cfg_pkg::rst_cp[2:0]});
		chk({30'h0, cal_run, divider_reset}, 32'h2);
		chk({29'h0, route}, 32'h0);
	endtask
	function automatic logic [3:0] pe_exp(input logic [7:0] v);
		return {v[2:0], v[conv_cfg_pkg::pe_boost_bit]};
	endfunction
	function automatic logic [2:0] route_exp(input logic single, input logic [7:0] v);
		if (!single) return v[conv_cfg_pkg::swap_bit] ? 3'h7 : 3'h1;
		case (v[1:0])
			conv_cfg_pkg::sel_b: return 3'h4;
			conv_cfg_pkg::sel_both: return 3'h1;
			default: return 3'h0;
		endcase
	endfunction
	initial begin
		{aresetn, awvalid, wvalid, bready, arvalid, rready, mode} = 7'h00;
		{awaddr, araddr, wdata, wstrb} = 56'h0;
		miscompares = 0;
		cmp_count = 0;
		void'($urandom(82680));
		repeat (5) @(posedge aclk);
		aresetn <= 1'b1;
		reset_vals();
		rdw(10'h000, 32'h0, err);
		wr(10'h010, $urandom, 4'hf, err);
		for (int i = 0; i < 10; i++) begin
			w = $urandom;
			if (i < 2) w[7:0] = i ? 8'h08 : 8'h0f;
			w[7:4] = conv_cfg_pkg::rst_preemph[7:4];
			d = w[7:0];
			wr(a_pe, w, 4'hf, ok);
			for (int k = 0; k < conv_cfg_pkg::lanes; k++) begin
				chk({28'h0, lane_preemph[k]}, {28'h0, pe_exp(d)});
			end
			wr(a_pe, ~w, 4'he, ok);
			rdw(a_pe, {24'h0, d}, ok);
		end
		for (int c = 0; c < 8; c++) begin
			d = {conv_cfg_pkg::rst_cp[7:3], 3'(c)};
			wr(a_cp, {24'($urandom), d}, 4'h1, ok);
			chk({29'h0, cp}, 32'(c));
			rdw(a_cp, {24'h0, d}, ok);
		end
		prev = 3'h0;
		for (int j = 0; j < 16; j++) begin
			@(posedge aclk);
			mode <= j[3];
			d = {conv_cfg_pkg::rst_insel[7:5], j[2], conv_cfg_pkg::rst_insel[3:2], j[1:0]};
			wr(a_ce, {24'($urandom), 8'h00}, 4'h1, ok);
			chk({30'h0, cal_run, divider_reset}, 32'h1);
			wr(a_is, {24'($urandom), d}, 4'h1, ok);
			repeat (3) @(negedge aclk);
			chk({29'h0, route}, {29'h0, prev});
			wr(a_ce, {24'($urandom), 8'h01}, 4'h1, ok);
			repeat (2) @(negedge aclk);
			chk({30'h0, cal_run, divider_reset}, 32'h2);
			prev = route_exp(j[3], d);
			chk({29'h0, route}, {29'h0, prev});
			rdw(a_is, {24'h0, d}, ok);
		end
		// second reset in mid-run must bring every register back
		@(posedge aclk);
		aresetn <= 1'b0;
		repeat (5) @(posedge aclk);
		aresetn <= 1'b1;
		reset_vals();
		test_done();
	end
endmodule
